// *** rtl/touch_timing_pkg.sv ***
// constants, register map and carrier types of the touch channel timing bank
// Operation
// - ungrouped channel sampled only when enabled
// - sampling cycle length fixed regardless enables
// - group enable clear stops all grouped sampling
// - enable bits 6..0 map inputs seven..one
// - button press limit in bits 7..4
// - press limit code decodes fixed table
// - button repeat interval in bits 3..0
// - repeat code n gives (n+1)*35 ms
// - hold repeat interval in group config one
// - hold event after touch exceeds minimum press
// - tap event when touch within minimum press
// - slide events independent of press timing
// - minimum press decodes (code+1)*35 ms
// - group press limit in group config two
// - slide repeat interval, adjusted by speed
// - auto recal only for enabled sampled channels
// - group auto recal, else manual request only
// - recal bits 6..0 map inputs seven..one
// - press beyond limit restarts recalibration
// - button repeat only with global repeat enable
// - manual request bit cleared when recal done
package touch_timing_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_BUTTONS = 7;
  localparam int NIBBLE_W = 4;
  localparam int HI_LSB = 4;
  localparam int GROUP_BIT = 7;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL_CONFIG = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_CHANNEL_SAMPLE_ENABLE = 8'h21;
  localparam logic [ADDR_W-1:0] ADDR_BUTTON_TIMING_CONFIG = 8'h22;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_TIMING_CONFIG_ONE = 8'h23;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_TIMING_CONFIG_TWO = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_AUTO_RECAL_ENABLE = 8'h25;
  localparam logic [ADDR_W-1:0] ADDR_CAL_ACTIVATE = 8'h26;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = 8'h2A;

  // reset values
  localparam logic [DATA_W-1:0] RST_GLOBAL_CONFIG = 8'h09;
  localparam logic [DATA_W-1:0] RST_CHANNEL_SAMPLE_ENABLE = 8'hFF;
  localparam logic [DATA_W-1:0] RST_BUTTON_TIMING_CONFIG = 8'hA4;
  localparam logic [DATA_W-1:0] RST_GROUP_TIMING_CONFIG_ONE = 8'h47;
  localparam logic [DATA_W-1:0] RST_GROUP_TIMING_CONFIG_TWO = 8'hD4;
  localparam logic [DATA_W-1:0] RST_AUTO_RECAL_ENABLE = 8'hFF;
  localparam logic [DATA_W-1:0] RST_CAL_ACTIVATE = 8'h00;
  localparam logic [DATA_W-1:0] RST_EVENT_STATUS = 8'h00;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

  // global config bit positions
  localparam int CFG_BUTTON_LIMIT_BIT = 3;
  localparam int CFG_BUTTON_REPEAT_BIT = 2;
  localparam int CFG_GROUP_LIMIT_BIT = 1;
  localparam int CFG_GROUP_REPEAT_BIT = 0;
  localparam logic [DATA_W-1:0] CFG_USED_MASK = 8'h0F;

  // event status bit positions
  localparam int ST_TAP = 0;
  localparam int ST_HOLD = 1;
  localparam int ST_SLIDE = 2;
  localparam int ST_BUTTON = 3;
  localparam int ST_BUTTON_RECAL = 4;
  localparam int ST_GROUP_RECAL = 5;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_KHZ = 50000;
  localparam int unsigned TICK_MS = 35;
  localparam int unsigned TICK_CYCLES_DEFAULT = TICK_MS * CLK_KHZ;
  localparam int CNT_W = 9;
  localparam int RPT_W = 5;
  localparam int unsigned PRESS_LIMIT_MS [16] = '{
    560, 840, 1120, 1400, 1680, 2240, 2800, 3360,
    3920, 4480, 5600, 6720, 7840, 8906, 10080, 11200
  };

  ////////////////////////////////////////////////////////////////////////////
  // carrier types
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic tap;
    logic hold;
    logic slide;
  } group_events_t;

  // press limit in whole ticks; non-multiples of the tick round down
  function automatic logic [CNT_W-1:0] press_limit_ticks(input logic [NIBBLE_W-1:0] code);
    press_limit_ticks = CNT_W'(PRESS_LIMIT_MS[code] / TICK_MS);
  endfunction : press_limit_ticks

  // code n means n+1 ticks of 35 ms
  function automatic logic [RPT_W-1:0] interval_ticks(input logic [NIBBLE_W-1:0] code);
    interval_ticks = RPT_W'(code) + RPT_W'(1);
  endfunction : interval_ticks

endpackage : touch_timing_pkg

// *** rtl/touch_channel_timing_config.sv ***
// register bank and press, repeat and recalibration timing for the touch channels
`timescale 1ns/1ns
module touch_channel_timing_config #(
  parameter int unsigned TICK_CYCLES = touch_timing_pkg::TICK_CYCLES_DEFAULT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire touch_timing_pkg::reg_req_t bus_req,
  output logic [touch_timing_pkg::DATA_W-1:0] rd_data,
  // touch detector side
  input wire logic [touch_timing_pkg::NUM_BUTTONS-1:0] button_touch,
  input wire logic group_touch,
  input wire logic group_slide,
  input wire logic slide_active,
  input wire logic [1:0] slide_speed,
  input wire logic [touch_timing_pkg::NUM_BUTTONS-1:0] group_channel_enable,
  // calibration engine side
  input wire logic [touch_timing_pkg::DATA_W-1:0] cal_done,
  output logic [touch_timing_pkg::DATA_W-1:0] cal_request,
  output logic [touch_timing_pkg::NUM_BUTTONS-1:0] button_auto_recal,
  output logic group_auto_recal,
  // sampling control
  output logic sample_strobe,
  output logic [touch_timing_pkg::NUM_BUTTONS-1:0] button_sampled,
  output logic [touch_timing_pkg::NUM_BUTTONS-1:0] group_sampled,
  // events
  output logic [touch_timing_pkg::NUM_BUTTONS-1:0] button_event,
  output touch_timing_pkg::group_events_t group_event
);

  localparam int NB = touch_timing_pkg::NUM_BUTTONS;
  localparam int DW = touch_timing_pkg::DATA_W;
  localparam int NW = touch_timing_pkg::NIBBLE_W;
  localparam int HL = touch_timing_pkg::HI_LSB;
  localparam int CW = touch_timing_pkg::CNT_W;
  localparam int RW = touch_timing_pkg::RPT_W;
  localparam int GB = touch_timing_pkg::GROUP_BIT;
  localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [RW-1:0] RPT_ONE = RW'(1);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [DW-1:0] global_config_reg;
  logic [DW-1:0] channel_sample_enable_reg;
  logic [DW-1:0] button_timing_config_reg;
  logic [DW-1:0] group_timing_config_one_reg;
  logic [DW-1:0] group_timing_config_two_reg;
  logic [DW-1:0] auto_recal_enable_reg;
  logic [DW-1:0] cal_activate_reg;
  logic [DW-1:0] cal_activate_next;
  logic [DW-1:0] event_status_reg;
  logic [DW-1:0] event_status_set;
  logic [DW-1:0] rd_data_reg;

  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick;
  logic sample_strobe_reg;
  logic [NB-1:0] button_sampled_reg;
  logic [NB-1:0] group_sampled_reg;
  logic [NB-1:0] button_auto_recal_reg;
  logic group_auto_recal_reg;

  logic [CW-1:0] btn_cnt_reg [NB];
  logic [RW-1:0] btn_rpt_reg [NB];
  logic [NB-1:0] btn_pressed_reg;
  logic [NB-1:0] btn_limit_hit_reg;
  logic [NB-1:0] btn_event_reg;
  logic [NB-1:0] btn_touch_eff;
  logic [NB-1:0] btn_force_recal;

  logic [CW-1:0] grp_cnt_reg;
  logic [RW-1:0] grp_rpt_reg;
  logic [RW-1:0] slide_rpt_reg;
  logic grp_pressed_reg;
  logic grp_hold_reg;
  logic grp_limit_hit_reg;
  logic grp_touch_eff;
  logic grp_force_recal;
  logic grp_tap_event_reg, grp_hold_event_reg, slide_event_reg;

  // decoded fields
  logic [NW-1:0] button_press_limit;
  logic [NW-1:0] button_repeat_interval;
  logic [NW-1:0] hold_repeat_interval;
  logic [NW-1:0] min_press_code;
  logic [NW-1:0] group_press_limit;
  logic [NW-1:0] slide_repeat_interval;
  logic group_sample_enable;
  logic group_auto_recal_enable;
  logic button_limit_recal_enable;
  logic button_repeat_enable;
  logic group_limit_recal_enable;
  logic group_repeat_enable;
  logic [RW-1:0] slide_interval_eff;

  assign button_press_limit = button_timing_config_reg[HL +: NW];
  assign button_repeat_interval = button_timing_config_reg[0 +: NW];
  assign hold_repeat_interval = group_timing_config_one_reg[HL +: NW];
  assign min_press_code = group_timing_config_one_reg[0 +: NW];
  assign group_press_limit = group_timing_config_two_reg[HL +: NW];
  assign slide_repeat_interval = group_timing_config_two_reg[0 +: NW];
  assign group_sample_enable = channel_sample_enable_reg[GB];
  assign group_auto_recal_enable = auto_recal_enable_reg[GB];
  assign button_limit_recal_enable = global_config_reg[touch_timing_pkg::CFG_BUTTON_LIMIT_BIT];
  assign button_repeat_enable = global_config_reg[touch_timing_pkg::CFG_BUTTON_REPEAT_BIT];
  assign group_limit_recal_enable = global_config_reg[touch_timing_pkg::CFG_GROUP_LIMIT_BIT];
  assign group_repeat_enable = global_config_reg[touch_timing_pkg::CFG_GROUP_REPEAT_BIT];

  // faster slides shorten the base interval, never below one tick
  always_comb begin
    slide_interval_eff = touch_timing_pkg::interval_ticks(slide_repeat_interval) >> slide_speed;
    if (slide_interval_eff == '0) begin
      slide_interval_eff = RPT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      global_config_reg <= touch_timing_pkg::RST_GLOBAL_CONFIG;
      channel_sample_enable_reg <= touch_timing_pkg::RST_CHANNEL_SAMPLE_ENABLE;
      button_timing_config_reg <= touch_timing_pkg::RST_BUTTON_TIMING_CONFIG;
      group_timing_config_one_reg <= touch_timing_pkg::RST_GROUP_TIMING_CONFIG_ONE;
      group_timing_config_two_reg <= touch_timing_pkg::RST_GROUP_TIMING_CONFIG_TWO;
      auto_recal_enable_reg <= touch_timing_pkg::RST_AUTO_RECAL_ENABLE;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        touch_timing_pkg::ADDR_GLOBAL_CONFIG: begin
          global_config_reg <= bus_req.wdata & touch_timing_pkg::CFG_USED_MASK;
        end
        touch_timing_pkg::ADDR_CHANNEL_SAMPLE_ENABLE: begin
          channel_sample_enable_reg <= bus_req.wdata;
        end
        touch_timing_pkg::ADDR_BUTTON_TIMING_CONFIG: begin
          button_timing_config_reg <= bus_req.wdata;
        end
        touch_timing_pkg::ADDR_GROUP_TIMING_CONFIG_ONE: begin
          group_timing_config_one_reg <= bus_req.wdata;
        end
        touch_timing_pkg::ADDR_GROUP_TIMING_CONFIG_TWO: begin
          group_timing_config_two_reg <= bus_req.wdata;
        end
        touch_timing_pkg::ADDR_AUTO_RECAL_ENABLE: begin
          auto_recal_enable_reg <= bus_req.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // calibration requests: a write stores its value, otherwise done clears;
  // a forced request from a long press is ORed last so it is never lost
  always_comb begin
    if (bus_req.wr && bus_req.addr == touch_timing_pkg::ADDR_CAL_ACTIVATE) begin
      cal_activate_next = bus_req.wdata;
    end else begin
      cal_activate_next = cal_activate_reg & ~cal_done;
    end
    cal_activate_next[NB-1:0] = cal_activate_next[NB-1:0] | btn_force_recal;
    cal_activate_next[GB] = cal_activate_next[GB] | grp_force_recal;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cal_activate_reg <= touch_timing_pkg::RST_CAL_ACTIVATE;
    end else begin
      cal_activate_reg <= cal_activate_next;
    end
  end

  // sticky event status, write one to clear, a new event wins
  always_comb begin
    event_status_set = '0;
    event_status_set[touch_timing_pkg::ST_TAP] = grp_tap_event_reg;
    event_status_set[touch_timing_pkg::ST_HOLD] = grp_hold_event_reg;
    event_status_set[touch_timing_pkg::ST_SLIDE] = slide_event_reg;
    event_status_set[touch_timing_pkg::ST_BUTTON] = |btn_event_reg;
    event_status_set[touch_timing_pkg::ST_BUTTON_RECAL] = |btn_force_recal;
    event_status_set[touch_timing_pkg::ST_GROUP_RECAL] = grp_force_recal;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      event_status_reg <= touch_timing_pkg::RST_EVENT_STATUS;
    end else if (bus_req.wr && bus_req.addr == touch_timing_pkg::ADDR_EVENT_STATUS) begin
      event_status_reg <= (event_status_reg & ~bus_req.wdata) | event_status_set;
    end else begin
      event_status_reg <= event_status_reg | event_status_set;
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (reset || !bus_req.rd) begin
      rd_data_reg <= touch_timing_pkg::READ_UNMAPPED;
    end else begin
      unique case (bus_req.addr)
        touch_timing_pkg::ADDR_GLOBAL_CONFIG: rd_data_reg <= global_config_reg;
        touch_timing_pkg::ADDR_CHANNEL_SAMPLE_ENABLE: rd_data_reg <= channel_sample_enable_reg;
        touch_timing_pkg::ADDR_BUTTON_TIMING_CONFIG: rd_data_reg <= button_timing_config_reg;
        touch_timing_pkg::ADDR_GROUP_TIMING_CONFIG_ONE: rd_data_reg <= group_timing_config_one_reg;
        touch_timing_pkg::ADDR_GROUP_TIMING_CONFIG_TWO: rd_data_reg <= group_timing_config_two_reg;
        touch_timing_pkg::ADDR_AUTO_RECAL_ENABLE: rd_data_reg <= auto_recal_enable_reg;
        touch_timing_pkg::ADDR_CAL_ACTIVATE: rd_data_reg <= cal_activate_reg;
        touch_timing_pkg::ADDR_EVENT_STATUS: rd_data_reg <= event_status_reg;
        default: rd_data_reg <= touch_timing_pkg::READ_UNMAPPED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // common time base; it free-runs so the cycle length never depends on enables
  always_ff @(posedge ref_clk) begin
    if (reset || tick_cnt_reg == TICK_LAST) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
    end
  end
  assign tick = (tick_cnt_reg == TICK_LAST);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sample_strobe_reg <= 1'b0;
      button_sampled_reg <= '0;
      group_sampled_reg <= '0;
      button_auto_recal_reg <= '0;
      group_auto_recal_reg <= 1'b0;
    end else begin
      sample_strobe_reg <= tick;
      button_sampled_reg <= channel_sample_enable_reg[NB-1:0];
      group_sampled_reg <= group_sample_enable ? group_channel_enable : '0;
      // a channel that is not sampled ignores its recal enable
      button_auto_recal_reg <= auto_recal_enable_reg[NB-1:0] &
                               channel_sample_enable_reg[NB-1:0];
      group_auto_recal_reg <= group_auto_recal_enable & group_sample_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ungrouped buttons
  assign btn_touch_eff = button_touch & button_sampled_reg;

  always_comb begin
    for (int i = 0; i < NB; i++) begin
      btn_force_recal[i] = btn_touch_eff[i] && btn_pressed_reg[i] && tick &&
                           button_limit_recal_enable && !btn_limit_hit_reg[i] &&
                           (btn_cnt_reg[i] + CNT_ONE >=
                            touch_timing_pkg::press_limit_ticks(button_press_limit));
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < NB; i++) begin
      if (reset) begin
        btn_cnt_reg[i] <= '0;
        btn_rpt_reg[i] <= '0;
        btn_pressed_reg[i] <= 1'b0;
        btn_limit_hit_reg[i] <= 1'b0;
        btn_event_reg[i] <= 1'b0;
      end else begin
        btn_pressed_reg[i] <= btn_touch_eff[i];
        btn_event_reg[i] <= 1'b0;
        if (!btn_touch_eff[i]) begin
          btn_cnt_reg[i] <= '0;
          btn_rpt_reg[i] <= '0;
          btn_limit_hit_reg[i] <= 1'b0;
        end else if (!btn_pressed_reg[i]) begin
          btn_event_reg[i] <= 1'b1;
        end else if (tick) begin
          if (btn_cnt_reg[i] != CNT_MAX) begin
            btn_cnt_reg[i] <= btn_cnt_reg[i] + CNT_ONE;
          end
          if (btn_force_recal[i]) begin
            btn_limit_hit_reg[i] <= 1'b1;
          end
          if (!button_repeat_enable) begin
            btn_rpt_reg[i] <= '0;
          end else if (btn_rpt_reg[i] + RPT_ONE >=
                       touch_timing_pkg::interval_ticks(button_repeat_interval)) begin
            btn_rpt_reg[i] <= '0;
            btn_event_reg[i] <= 1'b1;
          end else begin
            btn_rpt_reg[i] <= btn_rpt_reg[i] + RPT_ONE;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // grouped channels
  assign grp_touch_eff = group_touch && group_sample_enable && (|group_channel_enable);
  assign grp_force_recal = grp_touch_eff && grp_pressed_reg && tick &&
                           group_limit_recal_enable && !grp_limit_hit_reg &&
                           (grp_cnt_reg + CNT_ONE >=
                            touch_timing_pkg::press_limit_ticks(group_press_limit));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      grp_cnt_reg <= '0;
      grp_rpt_reg <= '0;
      grp_pressed_reg <= 1'b0;
      grp_hold_reg <= 1'b0;
      grp_limit_hit_reg <= 1'b0;
      grp_tap_event_reg <= 1'b0;
      grp_hold_event_reg <= 1'b0;
    end else begin
      grp_pressed_reg <= grp_touch_eff;
      grp_tap_event_reg <= 1'b0;
      grp_hold_event_reg <= 1'b0;
      if (!grp_touch_eff) begin
        // a release before the minimum press has passed is a tap
        if (grp_pressed_reg && !grp_hold_reg) begin
          grp_tap_event_reg <= 1'b1;
        end
        grp_cnt_reg <= '0;
        grp_rpt_reg <= '0;
        grp_hold_reg <= 1'b0;
        grp_limit_hit_reg <= 1'b0;
      end else if (grp_pressed_reg && tick) begin
        if (grp_cnt_reg != CNT_MAX) begin
          grp_cnt_reg <= grp_cnt_reg + CNT_ONE;
        end
        if (grp_force_recal) begin
          grp_limit_hit_reg <= 1'b1;
        end
        if (!grp_hold_reg) begin
          if (grp_cnt_reg + CNT_ONE > CW'(touch_timing_pkg::interval_ticks(min_press_code))) begin
            grp_hold_reg <= 1'b1;
            grp_hold_event_reg <= 1'b1;
            grp_rpt_reg <= '0;
          end
        end else if (!group_repeat_enable) begin
          grp_rpt_reg <= '0;
        end else if (grp_rpt_reg + RPT_ONE >=
                     touch_timing_pkg::interval_ticks(hold_repeat_interval)) begin
          grp_rpt_reg <= '0;
          grp_hold_event_reg <= 1'b1;
        end else begin
          grp_rpt_reg <= grp_rpt_reg + RPT_ONE;
        end
      end
    end
  end

  // slides run on their own counter, untouched by the press timing
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      slide_rpt_reg <= '0;
      slide_event_reg <= 1'b0;
    end else begin
      slide_event_reg <= 1'b0;
      if (!group_sample_enable) begin
        slide_rpt_reg <= '0;
      end else if (group_slide) begin
        slide_rpt_reg <= '0;
        slide_event_reg <= 1'b1;
      end else if (!slide_active) begin
        slide_rpt_reg <= '0;
      end else if (tick) begin
        if (slide_rpt_reg + RPT_ONE >= slide_interval_eff) begin
          slide_rpt_reg <= '0;
          slide_event_reg <= 1'b1;
        end else begin
          slide_rpt_reg <= slide_rpt_reg + RPT_ONE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rd_data = rd_data_reg;
  assign cal_request = cal_activate_reg;
  assign button_auto_recal = button_auto_recal_reg;
  assign group_auto_recal = group_auto_recal_reg;
  assign sample_strobe = sample_strobe_reg;
  assign button_sampled = button_sampled_reg;
  assign group_sampled = group_sampled_reg;
  assign button_event = btn_event_reg;
  assign group_event = {grp_tap_event_reg, grp_hold_event_reg, slide_event_reg};

endmodule : touch_channel_timing_config

// *** testbench/touch_channel_timing_assertions.sv ***
// port assertions for the touch channel timing bank
`timescale 1ns/1ns
module touch_channel_timing_assertions #(
  parameter int unsigned TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire touch_timing_pkg::reg_req_t bus_req,
  // touch and calibration side
  input wire logic [6:0] button_touch,
  input wire logic [6:0] group_channel_enable,
  input wire logic [7:0] cal_done,
  input wire logic [7:0] cal_request,
  input wire logic [6:0] button_auto_recal,
  // sampling and events
  input wire logic sample_strobe,
  input wire logic [6:0] button_sampled,
  input wire logic [6:0] group_sampled,
  input wire logic [6:0] button_event
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [31:0] gap;
  logic seen;
  logic wr_en_reg;
  logic wr_recal;
  assign wr_en_reg = bus_req.wr && bus_req.addr == 8'h21;
  assign wr_recal = bus_req.wr && bus_req.addr == 8'h25;
  ////////////////////////////////////////////////////////////////////////
  // cycles since the last tick; the first gap after reset is not judged
  always_ff @(posedge ref_clk) begin
    if (reset || sample_strobe) begin
      gap <= '0;
    end else begin
      gap <= gap + 32'd1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      seen <= 1'b0;
    end else if (sample_strobe) begin
      seen <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  AST_GROUP_SAMPLED: assert property (
    group_sampled == 7'h00 || group_sampled == $past(group_channel_enable))
    else $error("group sampling differs from group enables");
  AST_RECAL_SUBSET: assert property (
    (button_auto_recal & ~button_sampled) == 7'h00)
    else $error("auto recal on an unsampled input");
  AST_TICK_GAP: assert property (
    sample_strobe && seen |-> gap == TICK_CYCLES - 1)
    else $error("tick spacing wrong");
  AST_SAMPLE_WRITE: assert property (
    wr_en_reg |=> ##1 button_sampled == $past(bus_req.wdata[6:0], 2))
    else $error("input sampling does not follow enable bits");
  AST_GROUP_GATE: assert property (
    wr_en_reg && !bus_req.wdata[7] |=> ##1 group_sampled == 7'h00)
    else $error("grouped inputs sampled with group disabled");
  AST_RECAL_WRITE: assert property (
    wr_recal |=> ##1 button_auto_recal == ($past(bus_req.wdata[6:0], 2) & button_sampled))
    else $error("auto recal does not follow recal bits");
  AST_CAL_CLEAR: assert property (
    cal_done[0] && cal_request[0] && !bus_req.wr |=> !cal_request[0])
    else $error("request bit kept after recal done");
  AST_EVENT_CAUSE: assert property (
    button_event[0] |-> $past(button_touch[0] & button_sampled[0]))
    else $error("button event without touch");
  cover property (sample_strobe);
  cover property (button_event[0]);
  cover property (cal_done[0] && cal_request[0]);
endmodule : touch_channel_timing_assertions

bind touch_channel_timing_config touch_channel_timing_assertions #(
  .TICK_CYCLES(TICK_CYCLES)
) u_assert (
  .ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .button_touch(button_touch),
  .group_channel_enable(group_channel_enable), .cal_done(cal_done),
  .cal_request(cal_request), .button_auto_recal(button_auto_recal),
  .sample_strobe(sample_strobe), .button_sampled(button_sampled),
  .group_sampled(group_sampled), .button_event(button_event)
);

// *** testbench/touch_channel_timing_config_bench.sv ***
// self-checking bench for the touch channel timing bank
`timescale 1ns/1ns
module touch_channel_timing_config_bench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  touch_timing_pkg::reg_req_t bus_req = '0;
  logic [6:0] button_touch = 7'h00;
  logic group_touch = 1'b0;
  logic group_slide = 1'b0;
  logic slide_active = 1'b0;
  logic [6:0] group_channel_enable = 7'h55;
  logic [7:0] cal_done = 8'h00;
  logic [7:0] rd_data, cal_request;
  logic [6:0] button_auto_recal, button_sampled, group_sampled, button_event;
  logic group_auto_recal, sample_strobe;
  touch_timing_pkg::group_events_t group_event;
  logic [7:0] rst_tab [5] = '{8'hFF, 8'hA4, 8'h47, 8'hD4, 8'hFF};
  int num_errors = 0;
  int compares = 0;
  int n_btn = 0, n_tap = 0, n_hold = 0, n_slide = 0;
  int s_btn, s_tap, s_hold, s_slide;

  always #10 ref_clk = ~ref_clk;

  // short tick keeps press limits within a few hundred cycles
  touch_channel_timing_config #(.TICK_CYCLES(10)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
    .button_touch(button_touch), .group_touch(group_touch), .group_slide(group_slide),
    .slide_active(slide_active), .slide_speed(2'b00), .group_channel_enable(group_channel_enable),
    .cal_done(cal_done), .cal_request(cal_request), .button_auto_recal(button_auto_recal),
    .group_auto_recal(group_auto_recal), .sample_strobe(sample_strobe),
    .button_sampled(button_sampled), .group_sampled(group_sampled),
    .button_event(button_event), .group_event(group_event)
  );

  always @(posedge ref_clk) begin
    if (button_event[0] === 1'b1) n_btn++;
    if (group_event.tap === 1'b1) n_tap++;
    if (group_event.hold === 1'b1) n_hold++;
    if (group_event.slide === 1'b1) n_slide++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 check(rd_data, exp);
  endtask : rd_chk

  // holds a touch for n cycles, then lets release events land
  task automatic press(input logic [6:0] m, input logic g, input int n);
    s_btn = n_btn;
    s_tap = n_tap;
    s_hold = n_hold;
    s_slide = n_slide;
    @(posedge ref_clk);
    button_touch <= m;
    group_touch <= g;
    cyc(n);
    button_touch <= 7'h00;
    group_touch <= 1'b0;
    cyc(3);
    #1;
  endtask : press

  task automatic stop_test;
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) rd_chk(8'h21 + 8'(i), rst_tab[i]);
    rd_chk(8'h30, 8'h00);
    check(8'(button_sampled), 8'h7F);
    check(8'(group_sampled), 8'h55);
    check(8'(button_auto_recal), 8'h7F);
    wr(8'h22, 8'h01);
    rd_chk(8'h22, 8'h01);
    wr(8'h21, 8'h05);
    wr(8'h25, 8'h7E);
    cyc(2);
    #1 check(8'(button_sampled), 8'h05);
    check(8'(group_sampled), 8'h00);
    check(8'(button_auto_recal), 8'h04);
    check(8'(group_auto_recal), 8'h00);
    wr(8'h21, 8'hFF);
    wr(8'h25, 8'hFF);
    // limit code 0 is 16 ticks; repeat interval code 1 is 2 ticks
    wr(8'h20, 8'h08);
    press(7'h01, 1'b0, 120);
    check(cal_request, 8'h00);
    press(7'h01, 1'b0, 200);
    check(cal_request, 8'h01);
    check(8'(n_btn - s_btn), 8'h01);
    @(posedge ref_clk);
    cal_done <= 8'h01;
    @(posedge ref_clk);
    cal_done <= 8'h00;
    cyc(1);
    #1 check(cal_request, 8'h00);
    wr(8'h20, 8'h04);
    press(7'h01, 1'b0, 200);
    check(8'((n_btn - s_btn) inside {[9:11]}), 8'h01);
    wr(8'h21, 8'hFE);
    press(7'h01, 1'b0, 50);
    check(8'(n_btn - s_btn), 8'h00);
    // minimum press code 1 is 2 ticks
    wr(8'h20, 8'h00);
    wr(8'h23, 8'h01);
    press(7'h00, 1'b1, 5);
    check(8'(n_tap - s_tap), 8'h01);
    press(7'h00, 1'b1, 60);
    check(8'(n_hold - s_hold), 8'h01);
    check(8'(n_tap - s_tap), 8'h00);
    // one detected slide, then 10 ticks of slide at the 5 tick default rate
    s_slide = n_slide;
    @(posedge ref_clk);
    group_slide <= 1'b1;
    slide_active <= 1'b1;
    @(posedge ref_clk);
    group_slide <= 1'b0;
    cyc(100);
    slide_active <= 1'b0;
    cyc(3);
    #1 check(8'(n_slide - s_slide), 8'h03);
    wr(8'h21, 8'h7F);
    press(7'h00, 1'b1, 60);
    check(8'(n_hold - s_hold + n_tap - s_tap), 8'h00);
    stop_test();
  end
endmodule : touch_channel_timing_config_bench
